// ==== hw/tbc_pkg.sv ====
/*
 * tbc_pkg: constants and types of the bus controller.
 * assumes: 50 MHz clock, pulled-up open-drain bus.
 */
package tbc_pkg;

    // ------------------------------------------------------------
    // register offsets, one word each
    // ------------------------------------------------------------
    localparam logic [7:0] TBC_OFF_CTRL = 8'h00; // enable
    localparam logic [7:0] TBC_OFF_CMD = 8'h04; // command word
    localparam logic [7:0] TBC_OFF_TXD = 8'h08; // byte to send
    localparam logic [7:0] TBC_OFF_RXD = 8'h0c; // last byte received
    localparam logic [7:0] TBC_OFF_STAT = 8'h10; // status, w1c flags
    localparam logic [7:0] TBC_OFF_DIV = 8'h14; // half bit period in cycles

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TBC_CTRL_EN = 0; // controller enable
    localparam int TBC_CMD_START = 0; // start or repeated start
    localparam int TBC_CMD_WRITE = 1; // send txd byte
    localparam int TBC_CMD_READ = 2; // receive one byte
    localparam int TBC_CMD_STOP = 3; // stop and release bus
    localparam int TBC_CMD_NACK = 4; // withhold ack after read byte
    localparam int TBC_CMD_W = 5; // command field width
    localparam int TBC_ST_ACTIVE = 0; // sequence running
    localparam int TBC_ST_DONE = 1; // sequence finished, sticky
    localparam int TBC_ST_NACK = 2; // no ack seen, sticky
    localparam int TBC_ST_ARBITRATION_LOST_FLAG = 3; // arbitration lost, sticky
    localparam int TBC_ST_BUSY = 4; // bus between start and stop
    localparam int TBC_ST_OWNED = 5; // this controller holds the bus

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int TBC_CLK_NS = 20; // system clock period
    localparam int TBC_HALF_NS = 5000; // least half bit time, 100 kHz
    localparam int TBC_HALF_CYC = (TBC_HALF_NS + TBC_CLK_NS - 1) / TBC_CLK_NS;
    localparam logic [15:0] TBC_DIV_RST = 16'(TBC_HALF_CYC);
    localparam logic [15:0] TBC_DIV_MIN = 16'h0001; // floor of the divider
    localparam logic [3:0] TBC_LAST_BIT = 4'h8; // ninth bit index

    // ------------------------------------------------------------
    // engine states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TBC_IDLE = 4'h0,
        TBC_NEXT = 4'h1,
        TBC_STA_LOW = 4'h2,
        TBC_STA_HIGH = 4'h3,
        TBC_STA_HOLD = 4'h4,
        TBC_BIT_LOW = 4'h5,
        TBC_BIT_HIGH = 4'h6,
        TBC_STP_LOW = 4'h7,
        TBC_STP_HIGH = 4'h8,
        TBC_STP_REL = 4'h9
    } tbc_state_e;

    // all state of the controller top
    typedef struct packed {
        tbc_state_e st; // engine state
        logic en; // enable bit
        logic [15:0] div; // half period
        logic [7:0] txd; // transmit byte
        logic [7:0] rxd; // received byte
        logic [TBC_CMD_W-1:0] cmd; // pending command steps
        logic rd; // current byte is a read
        logic done; // sticky done
        logic nack; // sticky no-ack
        logic arbitration_lost_flag; // sticky arbitration lost
        logic owned; // bus held by us
        logic bus_busy; // start seen, stop not yet
        logic [15:0] cnt; // phase counter
        logic [3:0] bitn; // bit in byte
        logic [8:0] shf; // out and in shifter
        logic seen_high; // scl seen high this bit
        logic scl_oe; // pull scl low
        logic sda_oe; // pull sda low
        logic scl_p; // previous synced scl
        logic sda_p; // previous synced sda
        logic a_act; // data phase pending
        logic a_wr; // pending is a write
        logic [7:0] a_addr; // pending address
        logic [31:0] rdata; // read data
    } tbc_regs_s;

endpackage

// ==== hw/tbc_sync.sv ====
/*
 * tbc_sync: three-flop line synchroniser with agreement.
 * assumes: async inputs, lines idle high.
 */
`timescale 1ns/10ps
module tbc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] ff1; // first stage, read by ff2 only
        logic [WIDTH-1:0] ff2; // second stage
        logic [WIDTH-1:0] ff3; // third stage
        logic [WIDTH-1:0] out; // accepted level
    } tbc_sync_s;

    tbc_sync_s q;
    tbc_sync_s d;

    // next state: accept a bit once stages two and three agree
    always_comb begin
        d = q;
        d.ff1 = din;
        d.ff2 = q.ff1;
        d.ff3 = q.ff2;
        for (int i = 0; i < WIDTH; i++) begin
            if (q.ff2[i] == q.ff3[i]) begin
                d.out[i] = q.ff2[i];
            end
        end
    end

    // registers, lines idle high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{default: '1};
        end else begin
            q <= d;
        end
    end

    assign dout = q.out;

endmodule

// ==== hw/tbc_top.sv ====
/*
 * tbc_top: two-wire bus master, AHB-Lite registers.
 * assumes: one AHB-Lite master, word accesses;
 * pulled-up open-drain lines.
 */
// The implementer's own choices: the AHB-Lite register port and the register addresses.
// Behaviour
// - software switches direction before reading data
// - first byte: address high, direction bit low
// - start only on idle bus, SDA falls
// - direction one reads, zero writes
// - never master and slave at once
// - eight bits MSB first, ninth ack
// - missing ack means failed transfer
// - master nack ends slave transmission
// - stop is SDA rising, SCL high
// - time low, wait SCL rise, sync
// - wait while slave stretches SCL
// - direction bit: zero transmit, one receive
`timescale 1ns/10ps
module tbc_top
    import tbc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam tbc_regs_s TBC_RST = '{
        st: TBC_IDLE,
        div: TBC_DIV_RST,
        scl_p: 1'b1,
        sda_p: 1'b1,
        default: '0
    };

    tbc_regs_s q; // registered state
    tbc_regs_s d; // next state
    logic [1:0] lines; // synced {scl, sda}
    logic scl_s; // synced scl
    logic sda_s; // synced sda

    // read mux over the register map
    function automatic logic [31:0] tbc_read(input logic [7:0] a, input tbc_regs_s r);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == TBC_OFF_CTRL) begin
            v[TBC_CTRL_EN] = r.en;
        end else if (a == TBC_OFF_CMD) begin
            v[TBC_CMD_W-1:0] = r.cmd;
        end else if (a == TBC_OFF_TXD) begin
            v[7:0] = r.txd;
        end else if (a == TBC_OFF_RXD) begin
            v[7:0] = r.rxd;
        end else if (a == TBC_OFF_STAT) begin
            v[TBC_ST_ACTIVE] = (r.st != TBC_IDLE);
            v[TBC_ST_DONE] = r.done;
            v[TBC_ST_NACK] = r.nack;
            v[TBC_ST_ARBITRATION_LOST_FLAG] = r.arbitration_lost_flag;
            v[TBC_ST_BUSY] = r.bus_busy;
            v[TBC_ST_OWNED] = r.owned;
        end else if (a == TBC_OFF_DIV) begin
            v[15:0] = r.div;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // line synchroniser
    // ------------------------------------------------------------
    tbc_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .din({scl_i, sda_i}),
        .dout(lines)
    );

    assign scl_s = lines[1];
    assign sda_s = lines[0];

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic tick; // phase time elapsed
        logic go; // command accepted this cycle
        logic start_seen; // sda fell, scl high
        logic stop_seen; // sda rose, scl high
        logic b; // sampled bit
        logic ours; // bit driven by us
        logic [TBC_CMD_W-1:0] wcmd; // written command
        tick = 1'b0;
        go = 1'b0;
        start_seen = 1'b0;
        stop_seen = 1'b0;
        b = 1'b0;
        ours = 1'b0;
        wcmd = hwdata[TBC_CMD_W-1:0];
        d = q;
        tick = (q.cnt >= q.div - TBC_DIV_MIN);
        d.cnt = q.cnt + 16'h0001;

        // start and stop watch
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        start_seen = q.scl_p && scl_s && q.sda_p && !sda_s;
        stop_seen = q.scl_p && scl_s && !q.sda_p && sda_s;
        if (start_seen) begin
            d.bus_busy = 1'b1;
        end else if (stop_seen) begin
            d.bus_busy = 1'b0;
        end

        // ahb capture, read prefetch
        if (q.a_act && q.a_wr) begin
            if (q.a_addr == TBC_OFF_CTRL) begin
                d.en = hwdata[TBC_CTRL_EN];
            end else if (q.a_addr == TBC_OFF_CMD) begin
                go = q.en && (q.st == TBC_IDLE) && (wcmd != '0);
            end else if (q.a_addr == TBC_OFF_TXD) begin
                d.txd = hwdata[7:0];
            end else if (q.a_addr == TBC_OFF_STAT) begin
                // w1c; hardware sets below win
                d.done = q.done & ~hwdata[TBC_ST_DONE];
                d.nack = q.nack & ~hwdata[TBC_ST_NACK];
                d.arbitration_lost_flag = q.arbitration_lost_flag & ~hwdata[TBC_ST_ARBITRATION_LOST_FLAG];
            end else if (q.a_addr == TBC_OFF_DIV) begin
                d.div = (hwdata[15:0] < TBC_DIV_MIN) ? TBC_DIV_MIN : hwdata[15:0];
            end
        end
        d.a_act = hsel && htrans[1] && hready;
        if (d.a_act) begin
            d.a_wr = hwrite;
            d.a_addr = haddr[7:0];
            if (!hwrite) begin
                d.rdata = tbc_read(haddr[7:0], q);
            end
        end

        // bit engine
        case (q.st)
            TBC_IDLE: begin
                // scl held low while owned
                d.scl_oe = q.owned;
                if (go) begin
                    d.cmd = wcmd;
                    d.st = TBC_NEXT;
                end
            end
            TBC_NEXT: begin
                d.cnt = 16'h0000;
                d.seen_high = 1'b0;
                d.scl_oe = q.owned; // wait state, scl stays low while owned
                if (q.cmd[TBC_CMD_START]) begin
                    d.cmd[TBC_CMD_START] = 1'b0;
                    if (q.owned) begin
                        d.st = TBC_STA_LOW; // repeated start
                    end else if (q.bus_busy || !scl_s || !sda_s) begin
                        d.arbitration_lost_flag = 1'b1; // start only on a free bus
                        d.cmd = '0;
                    end else begin
                        d.st = TBC_STA_HIGH;
                    end
                end else if (q.cmd[TBC_CMD_WRITE] && q.owned) begin
                    d.cmd[TBC_CMD_WRITE] = 1'b0;
                    d.shf = {q.txd, 1'b1}; // msb first, ack released
                    d.bitn = 4'h0;
                    d.rd = 1'b0;
                    d.st = TBC_BIT_LOW;
                end else if (q.cmd[TBC_CMD_READ] && q.owned) begin
                    d.cmd[TBC_CMD_READ] = 1'b0; // read direction
                    d.shf = {8'hff, q.cmd[TBC_CMD_NACK]}; // nack ends slave send
                    d.bitn = 4'h0;
                    d.rd = 1'b1;
                    d.st = TBC_BIT_LOW;
                end else if (q.cmd[TBC_CMD_STOP] && q.owned) begin
                    d.cmd[TBC_CMD_STOP] = 1'b0;
                    d.st = TBC_STP_LOW; // release with stop
                end else begin
                    // data steps without the bus fail
                    if (!q.owned && (q.cmd[TBC_CMD_WRITE] || q.cmd[TBC_CMD_READ])) begin
                        d.nack = 1'b1; // no slave role
                    end
                    d.cmd = '0;
                    d.done = 1'b1;
                    d.st = TBC_IDLE;
                end
            end
            TBC_STA_LOW: begin
                // repeated start: free sda, scl low
                d.scl_oe = 1'b1;
                d.sda_oe = 1'b0;
                if (tick) begin
                    d.cnt = 16'h0000;
                    d.st = TBC_STA_HIGH;
                end
            end
            TBC_STA_HIGH: begin
                d.scl_oe = 1'b0;
                d.sda_oe = 1'b0;
                if (!scl_s) begin
                    d.cnt = 16'h0000; // wait for scl to rise
                end else if (tick) begin
                    d.cnt = 16'h0000;
                    if (sda_s) begin
                        d.st = TBC_STA_HOLD;
                    end else begin
                        d.arbitration_lost_flag = 1'b1; // another master holds sda
                        d.cmd = '0;
                        d.owned = 1'b0;
                        d.done = 1'b1;
                        d.st = TBC_IDLE;
                    end
                end
            end
            TBC_STA_HOLD: begin
                d.sda_oe = 1'b1; // sda falls while scl high
                d.scl_oe = 1'b0;
                if (tick) begin
                    d.owned = 1'b1;
                    d.scl_oe = 1'b1;
                    d.st = TBC_NEXT;
                end
            end
            TBC_BIT_LOW: begin
                d.scl_oe = 1'b1; // count our low period
                d.sda_oe = ~q.shf[8]; // change sda only while scl low
                if (tick) begin
                    d.cnt = 16'h0000;
                    d.seen_high = 1'b0;
                    d.st = TBC_BIT_HIGH;
                end
            end
            TBC_BIT_HIGH: begin
                d.scl_oe = 1'b0;
                if (scl_s) begin
                    d.seen_high = 1'b1; // high time from real rise
                end else if (!q.seen_high) begin
                    d.cnt = 16'h0000; // stretched by a slave
                end
                if ((q.seen_high && (tick || !scl_s)) || (scl_s && tick)) begin
                    // high over, or scl pulled low early
                    b = sda_s;
                    ours = q.rd ? (q.bitn == TBC_LAST_BIT) : (q.bitn != TBC_LAST_BIT);
                    d.cnt = 16'h0000;
                    d.shf = {q.shf[7:0], b};
                    if (ours && q.shf[8] && !b) begin
                        // lost: release, no stop, idle
                        d.arbitration_lost_flag = 1'b1;
                        d.owned = 1'b0;
                        d.sda_oe = 1'b0;
                        d.cmd = '0;
                        d.done = 1'b1;
                        d.st = TBC_IDLE;
                    end else if (q.bitn == TBC_LAST_BIT) begin
                        if (q.rd) begin
                            d.rxd = q.shf[7:0]; // last byte received
                        end else if (b) begin
                            d.nack = 1'b1; // no ack: failed transfer
                        end
                        d.sda_oe = 1'b0;
                        d.scl_oe = 1'b1; // ninth falling edge
                        d.st = TBC_NEXT;
                    end else begin
                        d.bitn = q.bitn + 4'h1;
                        d.scl_oe = 1'b1;
                        d.st = TBC_BIT_LOW;
                    end
                end
            end
            TBC_STP_LOW: begin
                d.scl_oe = 1'b1;
                d.sda_oe = 1'b1;
                if (tick) begin
                    d.cnt = 16'h0000;
                    d.st = TBC_STP_HIGH;
                end
            end
            TBC_STP_HIGH: begin
                d.scl_oe = 1'b0;
                d.sda_oe = 1'b1;
                if (!scl_s) begin
                    d.cnt = 16'h0000; // wait out a stretch
                end else if (tick) begin
                    d.cnt = 16'h0000;
                    d.st = TBC_STP_REL;
                end
            end
            TBC_STP_REL: begin
                d.sda_oe = 1'b0; // sda rises with scl high
                d.scl_oe = 1'b0;
                if (tick) begin
                    d.owned = 1'b0;
                    d.st = TBC_NEXT;
                end
            end
            default: begin
                d.st = TBC_IDLE;
            end
        endcase

        // foreign stop while owned
        if (q.owned && stop_seen && (q.st != TBC_STP_REL)) begin
            d.arbitration_lost_flag = 1'b1;
            d.owned = 1'b0;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.cmd = '0;
            d.done = 1'b1;
            d.st = TBC_IDLE;
        end

        // disable frees the bus
        if (!d.en) begin
            d.owned = 1'b0;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.cmd = '0;
            d.st = TBC_IDLE;
        end
    end

    // registers, disabled from reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= TBC_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata = q.rdata;
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay
    assign scl_o = 1'b0; // pull low only
    assign sda_o = 1'b0; // pull low only
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;

endmodule

// ==== test/tbc_top_asserts.sv ====
/*
 * tbc_top_asserts: pin checks.
 * assumes: pulled-up lines; div of 4 or more.
 */
`timescale 1ns/10ps
module tbc_top_asserts
    import tbc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe
);
    // --------
    // line checks
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // pins only ever pull low
    property p_odrain; !scl_o && !sda_o; endproperty
    a_odrain: assert property (p_odrain) else $error("line driven high");
    // quiet lines right after reset
    property p_rst_quiet; $rose(rst_b) |-> (!scl_oe && !sda_oe)[*8]; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("lines pulled after reset");
    // start only from an idle bus
    property p_start_idle; $rose(sda_oe) && !scl_oe |-> $past(sda_i) && $past(scl_i); endproperty
    a_start_idle: assert property (p_start_idle) else $error("start on busy lines");
    // clock follows start
    property p_start_clk; $rose(sda_oe) && !scl_oe |-> ##[1:1000] scl_oe; endproperty
    a_start_clk: assert property (p_start_clk) else $error("no clock after start");
    // stop with scl high
    property p_stop_shape; $fell(sda_oe) && !scl_oe |-> scl_i; endproperty
    a_stop_shape: assert property (p_stop_shape) else $error("stop with scl low");
    // bus free after stop
    property p_stop_free; $fell(sda_oe) && !scl_oe |-> ##1 (!sda_oe && !scl_oe)[*4]; endproperty
    a_stop_free: assert property (p_stop_free) else $error("bus kept after stop");
    // own low period is counted out
    property p_low_hold; $rose(scl_oe) |-> scl_oe[*4]; endproperty
    a_low_hold: assert property (p_low_hold) else $error("short clock low");
    // no pull while stretched
    property p_stretch; !scl_oe && !scl_i |=> !scl_oe; endproperty
    a_stretch: assert property (p_stretch) else $error("clock pulled while stretched");
endmodule

bind tbc_top tbc_top_asserts u_chk (.clk(clk), .rst_b(rst_b), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// ==== test/tbc_slave_model.sv ====
/*
 * tbc_slave_model: bus target.
 * assumes: wired-and lines; fixed address.
 */
`timescale 1ns/10ps
module tbc_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a // arbitrary own address
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] tx_base,
    input wire logic [7:0] stretch,
    output logic scl_oe, // pull only
    output logic sda_oe, // pull only
    output logic [7:0] rx_byte
);
    logic scl_p = 1'b1, sda_p = 1'b1;
    logic [1:0] mode = 2'd0; // 0 off, 1 address, 2 receive, 3 send
    logic [3:0] bitn = 4'h0;
    logic [7:0] sh = 8'h00, tsh = 8'h00, nsent = 8'h00, hold = 8'h00;
    logic mnack = 1'b0;
    wire logic [7:0] tx_now = tx_base + nsent;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        rx_byte = 8'h00;
    end
    // --------
    // bus follower
    // --------
    always @(posedge clk) begin
        scl_p <= scl;
        sda_p <= sda;
        scl_oe <= (hold != 8'h00);
        if (hold != 8'h00) hold <= hold - 8'h01;
        if (scl && scl_p && sda_p && !sda) begin // start wakes us
            mode <= 2'd1;
            bitn <= 4'h0;
            sda_oe <= 1'b0;
        end else if (scl && scl_p && !sda_p && sda) begin // stop
            mode <= 2'd0;
            sda_oe <= 1'b0;
        end else if (scl && !scl_p && mode != 2'd0) begin // msb first
            sh <= {sh[6:0], sda};
            if (bitn == 4'h8) mnack <= sda;
            bitn <= bitn + 4'h1;
        end else if (!scl && scl_p && mode != 2'd0) begin
            if (bitn == 4'h8) begin
                // ack match or data
                sda_oe <= (mode == 2'd1) ? (sh[7:1] == ADDR) : (mode == 2'd2);
                if (mode == 2'd1) mode <= (sh[7:1] != ADDR) ? 2'd0 : {1'b1, sh[0]};
                if (mode == 2'd2) rx_byte <= sh; // only after a match
            end else if (bitn == 4'h9) begin
                // byte done: stretch
                bitn <= 4'h0;
                hold <= stretch;
                sda_oe <= (mode == 2'd3) && !mnack && !tx_now[7];
                tsh <= {tx_now[6:0], 1'b0};
                if (mode == 2'd3 && mnack) mode <= 2'd0; // master nack ends it
                else if (mode == 2'd3) nsent <= nsent + 8'h01;
            end else if (mode == 2'd3) begin
                sda_oe <= !tsh[7];
                tsh <= {tsh[6:0], 1'b0};
            end
        end
    end
endmodule

// ==== test/two_wire_bus_controller_test.sv ====
/*
 * two_wire_bus_controller_test: tests of tbc_top.
 * assumes: slave model, pulled-up lines.
 */
`timescale 1ns/10ps
module two_wire_bus_controller_test
    import tbc_pkg::*;
;
    // --------
    // signals
    // --------
    localparam logic [6:0] SLV_ADDR = 7'h2a; // arbitrary target address
    localparam logic [4:0] C_STA = 5'h01, C_WR = 5'h02, C_RD = 5'h04, C_STP = 5'h08, C_NAK = 5'h10;
    logic clk, rst_b, hsel, hwrite, jam, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, st;
    logic [7:0] stretch, rx_byte;
    logic [7:0] tx_base = 8'h3c; // first byte the slave sends
    logic scl_oe, sda_oe, s_scl_oe, s_sda_oe;
    int n_fail = 0, check_count = 0;
    wire logic scl_i = !(scl_oe || s_scl_oe); // wired-and, pull-up
    wire logic sda_i = !(sda_oe || s_sda_oe || jam);
    tbc_top DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_i), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda_i), .sda_o(), .sda_oe(sda_oe));
    tbc_slave_model #(.ADDR(SLV_ADDR)) u_slave (.clk(clk), .scl(scl_i), .sda(sda_i),
        .tx_base(tx_base), .stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
        .rx_byte(rx_byte));
    // --------
    // tasks
    // --------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one ahb transfer
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        check(what, r, e);
    endtask
    // poll status
    task automatic wait_idle(output logic [31:0] s);
        @(posedge clk);
        for (int i = 0; i < 3000; i++) begin
            xfer(TBC_OFF_STAT, 1'b0, 32'h0, s);
            if (s[TBC_ST_ACTIVE] === 1'b0) break;
        end
        check("active", {31'h0, s[TBC_ST_ACTIVE]}, 32'h0);
    endtask
    task automatic run(input logic [7:0] txd, input logic [4:0] cmd, output logic [31:0] s);
        wr(TBC_OFF_STAT, 32'h0000000e);
        wr(TBC_OFF_TXD, {24'h0, txd});
        wr(TBC_OFF_CMD, {27'h0, cmd});
        wait_idle(s);
    endtask
    // status word from {owned, busy, arbitration_lost_flag, nack, done}, adjacent fields
    function automatic logic [31:0] stv(input logic [4:0] f);
        return 32'(f) << TBC_ST_DONE;
    endfunction
    task automatic finish_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // --------
    // clock, watchdog, tests
    // --------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        finish_test();
    end
    initial begin
        {rst_b, hsel, hwrite, jam, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        stretch = 8'h00;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        expect_reg(TBC_OFF_CTRL, 32'h0, "ctrl reset");
        check("hresp", {31'h0, hresp}, 32'h0);
        expect_reg(TBC_OFF_DIV, {16'h0, TBC_DIV_RST}, "div reset");
        wr(8'h18, 32'hffffffff);
        expect_reg(8'h18, 32'h0, "unmapped");
        wr(TBC_OFF_CMD, {27'h0, C_STA});
        wait_idle(st);
        check("disabled cmd", st, 32'h0);
        wr(TBC_OFF_CTRL, 32'h1);
        wr(TBC_OFF_DIV, 32'h8);
        expect_reg(TBC_OFF_DIV, 32'h8, "div");
        run(8'h00, C_WR, st);
        check("write unowned", st, stv(5'b00011));
        // write with a stretching slave
        stretch <= 8'h28;
        run({SLV_ADDR, 1'b0}, C_STA | C_WR, st);
        check("addr ack", st, stv(5'b11001));
        run(8'ha5, C_WR | C_STP, st);
        check("write stop", st, stv(5'b00001));
        check("slave byte", {24'h0, rx_byte}, 32'h000000a5);
        // no ack, then repeated start and reads
        stretch <= 8'h00;
        run({~SLV_ADDR, 1'b0}, C_STA | C_WR, st);
        check("no ack", st, stv(5'b11011));
        run({SLV_ADDR, 1'b1}, C_STA | C_WR, st);
        check("restart", st, stv(5'b11001));
        run(8'h00, C_RD, st);
        expect_reg(TBC_OFF_RXD, {24'h0, tx_base}, "rx first");
        run(8'h00, C_RD | C_NAK | C_STP, st);
        check("read stop", st, stv(5'b00001));
        expect_reg(TBC_OFF_RXD, {24'h0, tx_base + 8'h01}, "rx last");
        // sda held low by another party
        jam <= 1'b1;
        run(8'h00, C_STA, st);
        check("busy start", st, stv(5'b01101));
        jam <= 1'b0;
        fork
            run({SLV_ADDR, 1'b0}, C_STA | C_WR, st);
            begin
                @(posedge sda_oe);
                jam <= 1'b1;
            end
        join
        check("arb lost", st, stv(5'b01101));
        check("sda free", {31'h0, sda_oe}, 32'h0);
        jam <= 1'b0;
        repeat (8) @(posedge clk);
        expect_reg(TBC_OFF_STAT, stv(5'b00101), "bus free");
        finish_test();
    end
endmodule
